// *** rcr_capability_regs.v ***
// Notes on behaviour
// - Identity word: maker code low, part high.
// - Revision level bits 3:0 from boundary-scan version.
// - Die minor/major versions into bits 20:16, 23:21.
// - Assembly maker low half, type high half.
// - Feature list pointer 0x0100 in low half.
// - Assembly revision level in upper half.
// - Address width code 001: 34 bits only.
// - Feature bit 3 set: list present.
// - Feature bit 4 set: 16-bit IDs.
// - Feature bit 5 clear: no critical flow.
// - Feature bit 6 set: CRC recovery suppression.
// - Bits 8,9,10 set: routing and multicast.
// - Bit 28 set; bits 29, 31 clear.
// - Bit 30 clear: no local memory.
// - Port number of access; 0xFE over I2C.
// - Port total 0x10 in bits 15:8.
// - Registers follow the 1.3 interconnect layout.
`timescale 1ns/1ns
`include "rcr_capability_regs.vh"

module rcr_capability_regs #(
   parameter [15:0] MAKER_CODE         = 16'hA5A5, // Arbitrary value
   parameter [15:0] PART_CODE          = 16'h5A5A, // Arbitrary value
   parameter [15:0] ASSEMBLY_MAKER     = 16'hC3C3, // Arbitrary value
   parameter [15:0] ASSEMBLY_TYPE      = 16'h3C3C, // Arbitrary value
   parameter [15:0] ASSEMBLY_REVISION  = 16'h0001, // Arbitrary value
   parameter [7:0]  PORT_TOTAL         = `RCR_PORT_TOTAL_VAL
) (
   input  wire        clk,
   input  wire        resetn,
   input  wire        rdReq,
   input  wire [23:0] rdAddr,
   input  wire [7:0]  rdSrcPort,
   input  wire        rdFromI2c,
   input  wire        wrReq,
   input  wire [23:0] wrAddr,
   input  wire [31:0] wrData,
   input  wire [3:0]  jtagVersion,
   input  wire [4:0]  dieMinorVersion,
   input  wire [2:0]  dieMajorVersion,
   output reg         rdValid_reg,
   output reg  [31:0] rdData_reg,
   output reg         rdUnmapped_reg,
   output reg         wrDone_reg,
   output reg         wrUnmapped_reg
);

   // -------------------------------------------------------------------------
   // Word builders
   // -------------------------------------------------------------------------
   function [31:0] featureWord;
      input dummy;
      begin
         featureWord = `RCR_WORD_RESET;
         featureWord[`RCR_ADDRESS_WIDTH_LSB +: 3] = `RCR_ADDR_W_34_ONLY;
         featureWord[`RCR_FEAT_LIST_PRESENT_BIT]  = `RCR_FEAT_LIST_PRESENT_VAL;
         featureWord[`RCR_FEAT_WIDE_ID_BIT]       = `RCR_FEAT_WIDE_ID_VAL;
         featureWord[`RCR_FEAT_CRIT_FLOW_BIT]     = `RCR_FEAT_CRIT_FLOW_VAL;
         featureWord[`RCR_FEAT_CRC_SUPPRESS_BIT]  = `RCR_FEAT_CRC_SUPPRESS_VAL;
         featureWord[`RCR_FEAT_STD_ROUTE_BIT]     = `RCR_FEAT_STD_ROUTE_VAL;
         featureWord[`RCR_FEAT_WIDE_ROUTE_BIT]    = `RCR_FEAT_WIDE_ROUTE_VAL;
         featureWord[`RCR_FEAT_MULTICAST_BIT]     = `RCR_FEAT_MULTICAST_VAL;
         featureWord[`RCR_FEAT_SWITCH_BIT]        = `RCR_FEAT_SWITCH_VAL;
         featureWord[`RCR_FEAT_PROCESSOR_BIT]     = `RCR_FEAT_PROCESSOR_VAL;
         featureWord[`RCR_FEAT_BRIDGE_BIT]        = `RCR_FEAT_BRIDGE_VAL;
         featureWord[`RCR_FEAT_MEMORY_BIT]        = `RCR_FEAT_MEMORY_VAL;
      end
   endfunction

   // I2C has no port of its own, so it is given a number no port can carry.
   function [7:0] portNumber;
      input       fromI2c;
      input [7:0] srcPort;
      begin
         if (fromI2c) begin
            portNumber = `RCR_I2C_PORT_NUMBER;
         end else begin
            portNumber = srcPort;
         end
      end
   endfunction

   // -------------------------------------------------------------------------
   // Version levels
   // -------------------------------------------------------------------------
   wire [3:0] revisionLevel;
   wire [4:0] minorVersion;
   wire [2:0] majorVersion;

   rcr_info_capture infoCapture (
      .clk               (clk),
      .resetn            (resetn),
      .jtagVersion       (jtagVersion),
      .dieMinorVersion   (dieMinorVersion),
      .dieMajorVersion   (dieMajorVersion),
      .revisionLevel_reg (revisionLevel),
      .minorVersion_reg  (minorVersion),
      .majorVersion_reg  (majorVersion),
      .captured_reg      ()
   );

   // -------------------------------------------------------------------------
   // Register words; unlisted bits are tied to zero
   // -------------------------------------------------------------------------
   reg [31:0] wordIdentity;
   reg [31:0] wordInformation;
   reg [31:0] wordAssyIdentity;
   reg [31:0] wordAssyInformation;
   reg [31:0] wordPortInfo;
   wire [31:0] wordFeatures;

   assign wordFeatures = featureWord(1'b0);

   always @* begin
      wordIdentity = `RCR_WORD_RESET;
      wordIdentity[`RCR_MAKER_CODE_LSB +: 16] = MAKER_CODE;
      wordIdentity[`RCR_PART_CODE_LSB +: 16]  = PART_CODE;

      wordInformation = `RCR_WORD_RESET;
      wordInformation[`RCR_REVISION_LEVEL_LSB +: 4] = revisionLevel;
      wordInformation[`RCR_MINOR_VERSION_LSB +: 5]  = minorVersion;
      wordInformation[`RCR_MAJOR_VERSION_LSB +: 3]  = majorVersion;

      wordAssyIdentity = `RCR_WORD_RESET;
      wordAssyIdentity[`RCR_ASSEMBLY_MAKER_LSB +: 16] = ASSEMBLY_MAKER;
      wordAssyIdentity[`RCR_ASSEMBLY_TYPE_LSB +: 16]  = ASSEMBLY_TYPE;

      wordAssyInformation = `RCR_WORD_RESET;
      wordAssyInformation[`RCR_FEATURE_POINTER_LSB +: 16]   = `RCR_FEATURE_POINTER_VAL;
      wordAssyInformation[`RCR_ASSEMBLY_REVISION_LSB +: 16] = ASSEMBLY_REVISION;

      wordPortInfo = `RCR_WORD_RESET;
      wordPortInfo[`RCR_PORT_NUMBER_LSB +: 8] = portNumber(rdFromI2c, rdSrcPort);
      wordPortInfo[`RCR_PORT_TOTAL_LSB +: 8]  = PORT_TOTAL;
   end

   // -------------------------------------------------------------------------
   // Decode, laid out as the standard capability block
   // -------------------------------------------------------------------------
   wire [31:0] rdWord;
   wire        rdHit;
   wire [31:0] wrWordUnused;
   wire        wrHit;

   rcr_word_select readSelect (
      .addr                (rdAddr),
      .wordIdentity        (wordIdentity),
      .wordInformation     (wordInformation),
      .wordAssyIdentity    (wordAssyIdentity),
      .wordAssyInformation (wordAssyInformation),
      .wordFeatures        (wordFeatures),
      .wordPortInfo        (wordPortInfo),
      .data                (rdWord),
      .hit                 (rdHit)
   );

   // Writes only need the hit flag; a second copy of the decode is used and its data output is left unused.
   rcr_word_select writeSelect (
      .addr                (wrAddr),
      .wordIdentity        (wordIdentity),
      .wordInformation     (wordInformation),
      .wordAssyIdentity    (wordAssyIdentity),
      .wordAssyInformation (wordAssyInformation),
      .wordFeatures        (wordFeatures),
      .wordPortInfo        (wordPortInfo),
      .data                (wrWordUnused),
      .hit                 (wrHit)
   );

   // -------------------------------------------------------------------------
   // Answer registers
   // -------------------------------------------------------------------------
   reg        rdValid_next;
   reg [31:0] rdData_next;
   reg        rdUnmapped_next;
   reg        wrDone_next;
   reg        wrUnmapped_next;

   always @* begin
      rdValid_next    = rdReq;
      rdData_next     = `RCR_WORD_RESET;
      rdUnmapped_next = 1'b0;
      if (rdReq) begin
         rdData_next     = rdWord;
         rdUnmapped_next = ~rdHit;
      end
      // A write is acknowledged but never stored: every word here is read-only.
      wrDone_next     = wrReq;
      wrUnmapped_next = wrReq & ~wrHit;
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdValid_reg    <= 1'b0;
         rdData_reg     <= `RCR_WORD_RESET;
         rdUnmapped_reg <= 1'b0;
         wrDone_reg     <= 1'b0;
         wrUnmapped_reg <= 1'b0;
      end else begin
         rdValid_reg    <= rdValid_next;
         rdData_reg     <= rdData_next;
         rdUnmapped_reg <= rdUnmapped_next;
         wrDone_reg     <= wrDone_next;
         wrUnmapped_reg <= wrUnmapped_next;
      end
   end

endmodule // rcr_capability_regs

// *** rcr_capability_regs.vh ***
`ifndef RCR_CAPABILITY_REGS_VH
`define RCR_CAPABILITY_REGS_VH

// ----------------------------------------------------------------------------
// Register byte offsets within the capability space
// ----------------------------------------------------------------------------
`define RCR_OFS_DEVICE_IDENTITY        24'h000000
`define RCR_OFS_DEVICE_INFORMATION     24'h000004
`define RCR_OFS_ASSEMBLY_IDENTITY      24'h000008
`define RCR_OFS_ASSEMBLY_INFORMATION   24'h00000C
`define RCR_OFS_ELEMENT_FEATURES       24'h000010
`define RCR_OFS_SWITCH_PORT_INFO       24'h000014

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RCR_MAKER_CODE_LSB             0
`define RCR_PART_CODE_LSB              16
`define RCR_REVISION_LEVEL_LSB         0
`define RCR_MINOR_VERSION_LSB          16
`define RCR_MAJOR_VERSION_LSB          21
`define RCR_ASSEMBLY_MAKER_LSB         0
`define RCR_ASSEMBLY_TYPE_LSB          16
`define RCR_FEATURE_POINTER_LSB        0
`define RCR_ASSEMBLY_REVISION_LSB      16
`define RCR_ADDRESS_WIDTH_LSB          0
`define RCR_FEAT_LIST_PRESENT_BIT      3
`define RCR_FEAT_WIDE_ID_BIT           4
`define RCR_FEAT_CRIT_FLOW_BIT         5
`define RCR_FEAT_CRC_SUPPRESS_BIT      6
`define RCR_FEAT_STD_ROUTE_BIT         8
`define RCR_FEAT_WIDE_ROUTE_BIT        9
`define RCR_FEAT_MULTICAST_BIT         10
`define RCR_FEAT_SWITCH_BIT            28
`define RCR_FEAT_PROCESSOR_BIT         29
`define RCR_FEAT_MEMORY_BIT            30
`define RCR_FEAT_BRIDGE_BIT            31
`define RCR_PORT_NUMBER_LSB            0
`define RCR_PORT_TOTAL_LSB             8

// ----------------------------------------------------------------------------
// Fixed values
// ----------------------------------------------------------------------------
`define RCR_FEATURE_POINTER_VAL        16'h0100
`define RCR_ADDR_W_66_50_34            3'h7
`define RCR_ADDR_W_66_34               3'h5
`define RCR_ADDR_W_50_34               3'h2
`define RCR_ADDR_W_34_ONLY             3'h1
`define RCR_FEAT_LIST_PRESENT_VAL      1'h1
`define RCR_FEAT_WIDE_ID_VAL           1'h1
`define RCR_FEAT_CRIT_FLOW_VAL         1'h0
`define RCR_FEAT_CRC_SUPPRESS_VAL      1'h1
`define RCR_FEAT_STD_ROUTE_VAL         1'h1
`define RCR_FEAT_WIDE_ROUTE_VAL        1'h1
`define RCR_FEAT_MULTICAST_VAL         1'h1
`define RCR_FEAT_SWITCH_VAL            1'h1
`define RCR_FEAT_PROCESSOR_VAL         1'h0
`define RCR_FEAT_MEMORY_VAL            1'h0
`define RCR_FEAT_BRIDGE_VAL            1'h0
`define RCR_I2C_PORT_NUMBER            8'hFE
`define RCR_PORT_TOTAL_VAL             8'h10
`define RCR_WORD_RESET                 32'h00000000

// ----------------------------------------------------------------------------
// Timing: a read answers this many clocks after it is taken
// ----------------------------------------------------------------------------
`define RCR_READ_LATENCY               1

`endif

// *** rcr_info_capture.v ***
`timescale 1ns/1ns
`include "rcr_capability_regs.vh"

// ----------------------------------------------------------------------------
// Catches the version levels once, at the first edge after reset release
// ----------------------------------------------------------------------------
module rcr_info_capture (
   input  wire       clk,
   input  wire       resetn,
   input  wire [3:0] jtagVersion,
   input  wire [4:0] dieMinorVersion,
   input  wire [2:0] dieMajorVersion,
   output reg  [3:0] revisionLevel_reg,
   output reg  [4:0] minorVersion_reg,
   output reg  [2:0] majorVersion_reg,
   output reg        captured_reg
);

   // Version sources are straps; a constant is loaded under reset and the
   // real values are taken by the clock once reset has gone away.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         revisionLevel_reg <= 4'h0;
         minorVersion_reg  <= 5'h00;
         majorVersion_reg  <= 3'h0;
         captured_reg      <= 1'b0;
      end else if (!captured_reg) begin
         revisionLevel_reg <= jtagVersion;
         minorVersion_reg  <= dieMinorVersion;
         majorVersion_reg  <= dieMajorVersion;
         captured_reg      <= 1'b1;
      end
   end

endmodule // rcr_info_capture

// *** rcr_word_select.v ***
`timescale 1ns/1ns
`include "rcr_capability_regs.vh"

// ----------------------------------------------------------------------------
// Address decode and read mux over the six capability words
// ----------------------------------------------------------------------------
module rcr_word_select (
   input  wire [23:0] addr,
   input  wire [31:0] wordIdentity,
   input  wire [31:0] wordInformation,
   input  wire [31:0] wordAssyIdentity,
   input  wire [31:0] wordAssyInformation,
   input  wire [31:0] wordFeatures,
   input  wire [31:0] wordPortInfo,
   output reg  [31:0] data,
   output reg         hit
);

   // Byte lanes are ignored: every word is read whole.
   wire [23:0] wordAddr;

   assign wordAddr = {addr[23:2], 2'h0};

   always @* begin
      data = `RCR_WORD_RESET;
      hit  = 1'b1;
      if (wordAddr == `RCR_OFS_DEVICE_IDENTITY) begin
         data = wordIdentity;
      end else if (wordAddr == `RCR_OFS_DEVICE_INFORMATION) begin
         data = wordInformation;
      end else if (wordAddr == `RCR_OFS_ASSEMBLY_IDENTITY) begin
         data = wordAssyIdentity;
      end else if (wordAddr == `RCR_OFS_ASSEMBLY_INFORMATION) begin
         data = wordAssyInformation;
      end else if (wordAddr == `RCR_OFS_ELEMENT_FEATURES) begin
         data = wordFeatures;
      end else if (wordAddr == `RCR_OFS_SWITCH_PORT_INFO) begin
         data = wordPortInfo;
      end else begin
         hit = 1'b0;
      end
   end

endmodule // rcr_word_select

// *** rcr_capability_regs_props.sv ***
`timescale 1ns/1ns
module rcr_capability_regs_props #(
   parameter [7:0] PORT_TOTAL = 8'h10
) (
   input wire        clk,
   input wire        resetn,
   input wire        rdReq,
   input wire [23:0] rdAddr,
   input wire [7:0]  rdSrcPort,
   input wire        rdFromI2c,
   input wire        wrReq,
   input wire [23:0] wrAddr,
   input wire        rdValid_reg,
   input wire [31:0] rdData_reg,
   input wire        rdUnmapped_reg,
   input wire        wrDone_reg,
   input wire        wrUnmapped_reg
);
   // ---------------------------------------------
   // Answer timing and word contents
   // ---------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   wire [21:0] rw = rdAddr[23:2];
   chk_read_answer: assert property (
      rdValid_reg == $past(rdReq))
      else $error("read answer timing wrong");
   chk_write_answer: assert property (
      wrReq |=> wrDone_reg && wrUnmapped_reg == ($past(wrAddr[23:2]) > 22'h5))
      else $error("write answer wrong");
   chk_no_stray_done: assert property (
      !wrReq |=> !wrDone_reg && !wrUnmapped_reg)
      else $error("write answer without request");
   chk_idle_data_zero: assert property (
      !rdValid_reg |-> rdData_reg == 32'h00000000 && !rdUnmapped_reg)
      else $error("read data outside answer");
   chk_unmapped_zero: assert property (
      rdReq && rw > 22'h5 |=> rdUnmapped_reg && rdData_reg == 32'h00000000)
      else $error("unmapped read not zero");
   chk_features_word: assert property (
      rdReq && rw == 22'h4 |=> !rdUnmapped_reg && rdData_reg == 32'h10000759)
      else $error("feature word wrong");
   chk_port_number: assert property (
      rdReq && rw == 22'h5 |=> rdData_reg[7:0] == ($past(rdFromI2c) ? 8'hFE : $past(rdSrcPort)))
      else $error("port number wrong");
   chk_port_total: assert property (
      rdReq && rw == 22'h5 |=> rdData_reg[31:8] == {16'h0000, PORT_TOTAL})
      else $error("port total wrong");
   chk_info_reserved: assert property (
      rdReq && rw == 22'h1 |=> rdData_reg[31:24] == 8'h00 && rdData_reg[15:4] == 12'h000)
      else $error("reserved info bits set");
   chk_pointer_field: assert property (
      rdReq && rw == 22'h3 |=> rdData_reg[15:0] == 16'h0100)
      else $error("feature pointer wrong");
   cover property (rdReq && rdFromI2c && rw == 22'h5);
   cover property (rdReq ##1 rdReq);
   cover property (rdReq && wrReq);
   cover property (wrReq && wrAddr[23:2] > 22'h5);
endmodule // rcr_capability_regs_props
bind rcr_capability_regs rcr_capability_regs_props #(.PORT_TOTAL(PORT_TOTAL)) rcr_capability_regs_props_i (
   .clk(clk), .resetn(resetn), .rdReq(rdReq), .rdAddr(rdAddr), .rdSrcPort(rdSrcPort), .rdFromI2c(rdFromI2c),
   .wrReq(wrReq), .wrAddr(wrAddr), .rdValid_reg(rdValid_reg), .rdData_reg(rdData_reg),
   .rdUnmapped_reg(rdUnmapped_reg), .wrDone_reg(wrDone_reg), .wrUnmapped_reg(wrUnmapped_reg));

// *** rcr_requester_model.sv ***
`timescale 1ns/1ns
module rcr_requester_model (
   input  logic        clk,
   output logic        rdReq,
   output logic [23:0] rdAddr,
   output logic [7:0]  rdSrcPort,
   output logic        rdFromI2c,
   output logic        wrReq,
   output logic [23:0] wrAddr,
   output logic [31:0] wrData,
   input  logic        rdValid_reg,
   input  logic [31:0] rdData_reg,
   input  logic        rdUnmapped_reg,
   input  logic        wrDone_reg,
   input  logic        wrUnmapped_reg
);
   logic [32:0] gotRd[$];
   logic        gotWr[$];
   initial begin
      {rdReq, rdAddr, rdSrcPort, rdFromI2c} = '0;
      {wrReq, wrAddr, wrData} = '0;
   end
   // One slot per clock; an unused side shows inverted lines so a stale value never looks valid
   task automatic acc(input logic re, input logic [23:0] ra, input logic [7:0] rp, input logic ri,
                      input logic we, input logic [23:0] wa, input logic [31:0] wd);
      @(posedge clk);
      rdReq     <= re;
      rdAddr    <= re ? ra : ~rdAddr;
      rdSrcPort <= re ? rp : ~rdSrcPort;
      rdFromI2c <= re ? ri : ~rdFromI2c;
      wrReq     <= we;
      wrAddr    <= we ? wa : ~wrAddr;
      wrData    <= we ? wd : ~wrData;
   endtask
   always @(posedge clk) begin
      if (rdValid_reg) gotRd.push_back({rdUnmapped_reg, rdData_reg});
      if (wrDone_reg) gotWr.push_back(wrUnmapped_reg);
   end
endmodule // rcr_requester_model

// *** rcr_capability_regs_tb.sv ***
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
   $display("[FAIL] %0t got %h expected %h", $time, (g), (e)); end end
module rcr_capability_regs_tb;
   localparam [15:0] MAKER = 16'h1357; // Arbitrary value
   localparam [15:0] PART  = 16'h2468; // Arbitrary value
   localparam [15:0] AMAKR = 16'h9BDF; // Arbitrary value
   localparam [15:0] ATYPE = 16'hACE1; // Arbitrary value
   localparam [15:0] AREV  = 16'h0ACE; // Arbitrary value
   logic        clk = 1'b0, resetn = 1'b0;
   logic        rdReq, rdFromI2c, wrReq, rdValid_reg, rdUnmapped_reg, wrDone_reg, wrUnmapped_reg;
   logic [23:0] rdAddr, wrAddr;
   logic [7:0]  rdSrcPort;
   logic [31:0] wrData, rdData_reg, r, d, seed = 32'h00000043;
   logic [3:0]  jtagVersion, capRev;
   logic [4:0]  dieMinorVersion, capMin;
   logic [2:0]  dieMajorVersion, capMaj;
   logic [32:0] expRd[$];
   logic        expWr[$];
   int          err_total = 0, num_checks = 0;
   always #20 clk = ~clk;
   rcr_capability_regs #(.MAKER_CODE(MAKER), .PART_CODE(PART), .ASSEMBLY_MAKER(AMAKR), .ASSEMBLY_TYPE(ATYPE),
      .ASSEMBLY_REVISION(AREV)) rcr_capability_regs_i (.clk(clk), .resetn(resetn), .rdReq(rdReq),
      .rdAddr(rdAddr), .rdSrcPort(rdSrcPort), .rdFromI2c(rdFromI2c), .wrReq(wrReq), .wrAddr(wrAddr),
      .wrData(wrData), .jtagVersion(jtagVersion), .dieMinorVersion(dieMinorVersion),
      .dieMajorVersion(dieMajorVersion), .rdValid_reg(rdValid_reg), .rdData_reg(rdData_reg),
      .rdUnmapped_reg(rdUnmapped_reg), .wrDone_reg(wrDone_reg), .wrUnmapped_reg(wrUnmapped_reg));
   rcr_requester_model rcr_requester_model_i (.clk(clk), .rdReq(rdReq), .rdAddr(rdAddr), .rdSrcPort(rdSrcPort),
      .rdFromI2c(rdFromI2c), .wrReq(wrReq), .wrAddr(wrAddr), .wrData(wrData), .rdValid_reg(rdValid_reg),
      .rdData_reg(rdData_reg), .rdUnmapped_reg(rdUnmapped_reg), .wrDone_reg(wrDone_reg),
      .wrUnmapped_reg(wrUnmapped_reg));
   // ---------------------------------------------
   // Expectations and stimulus helpers
   // ---------------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [32:0] expWord(input logic [23:0] a, input logic [7:0] p, input logic i2c);
      case (a[23:2])
         22'h0: return {1'b0, PART, MAKER};
         22'h1: return {1'b0, 8'h00, capMaj, capMin, 12'h000, capRev};
         22'h2: return {1'b0, ATYPE, AMAKR};
         22'h3: return {1'b0, AREV, 16'h0100};
         22'h4: return {1'b0, 32'h10000759};
         22'h5: return {1'b0, 16'h0000, 8'h10, i2c ? 8'hFE : p};
         default: return {1'b1, 32'h00000000};
      endcase
   endfunction
   task automatic go(input logic re, input logic [23:0] ra, input logic [7:0] rp, input logic ri,
                     input logic we, input logic [23:0] wa, input logic [31:0] wd);
      rcr_requester_model_i.acc(re, ra, rp, ri, we, wa, wd);
      if (re) expRd.push_back(expWord(ra, rp, ri));
      if (we) expWr.push_back(wa[23:2] > 22'h5);
   endtask
   task automatic test_done();
      if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      test_done();
   end
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      r = xs();
      {jtagVersion, dieMinorVersion, dieMajorVersion} = r[11:0];
      {capRev, capMin, capMaj} = r[11:0];
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      repeat (2) @(posedge clk);
      r = xs();
      // Straps are caught once, so later changes must not show
      {jtagVersion, dieMinorVersion, dieMajorVersion} <= r[11:0];
      for (int i = 0; i < 8; i++) go(1'b1, 24'(i * 4), 8'h03, 1'b0, 1'b0, 24'h0, 32'h0);
      go(1'b1, 24'h000014, 8'h07, 1'b1, 1'b0, 24'h0, 32'h0);
      go(1'b1, 24'hFFFFFC, 8'h07, 1'b0, 1'b1, 24'hFFFFFC, 32'hFFFFFFFF);
      go(1'b1, 24'h000013, 8'h00, 1'b0, 1'b0, 24'h0, 32'h0);
      for (int i = 0; i < 7; i++) go(1'b1, 24'(i * 4), 8'hFF, 1'b0, 1'b1, 24'(i * 4), ~32'h0);
      repeat (400) begin
         r = xs();
         d = xs();
         go(r[0] | r[1], r[30] ? r[23:0] : {19'h0, r[6:2]}, r[14:7], r[15], r[16],
            r[29] ? d[23:0] : {19'h0, d[4:0]}, d);
      end
      go(1'b0, 24'h0, 8'h0, 1'b0, 1'b0, 24'h0, 32'h0);
      repeat (3) @(posedge clk);
      `CHK(rcr_requester_model_i.gotRd.size(), expRd.size())
      `CHK(rcr_requester_model_i.gotWr.size(), expWr.size())
      foreach (expRd[i]) if (i < rcr_requester_model_i.gotRd.size())
         `CHK(rcr_requester_model_i.gotRd[i], expRd[i])
      foreach (expWr[i]) if (i < rcr_requester_model_i.gotWr.size())
         `CHK(rcr_requester_model_i.gotWr[i], expWr[i])
      test_done();
   end
endmodule // rcr_capability_regs_tb
